// ===== rtl/tdh_defines.vh
`ifndef TDH_DEFINES_VH
`define TDH_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TDH_OFS_DISC1 7'h00
`define TDH_OFS_DISC2 7'h04
`define TDH_OFS_DISC3 7'h08
`define TDH_OFS_HK1 7'h0c
`define TDH_OFS_LIMIT 7'h48
`define TDH_OFS_ISTAT 7'h4c
`define TDH_OFS_IMASK 7'h50

// ----------------------------------------
// field positions
// ----------------------------------------
`define TDH_W1_COIL_LSB 9
`define TDH_W1_TRIP_BIT 15
`define TDH_W2_TRIP_LSB 0
`define TDH_W2_TEST_LSB 5
`define TDH_NUM_FLAGS 15
`define TDH_NUM_HK 15

// ----------------------------------------
// reset values
// ----------------------------------------
`define TDH_LIMIT_RST 16'h000a
`define TDH_IMASK_RST 15'h0000

// ----------------------------------------
// timing: duration limit counts 1 ms ticks
// ----------------------------------------
`define TDH_CLK_MHZ 200
`define TDH_TICK_US 1000
`define TDH_TICK_CYCLES (`TDH_TICK_US * `TDH_CLK_MHZ)

// ----------------------------------------
// saturation limits of a health word
// ----------------------------------------
`define TDH_HK_MAX 16'h7fff
`define TDH_HK_MIN 16'h8000

`endif

// ===== rtl/tdh_status.v
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "tdh_defines.vh"

module tdh_status #(
	parameter RAW_W = 18,
	parameter CNT_W = 16,
	parameter TICK_CYCLES = `TDH_TICK_CYCLES
) (
	input wire hclk, // bus clock
	input wire hresetn, // async reset, low
	input wire hsel, // slave select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write flag
	input wire [2:0] hsize, // transfer size
	input wire [31:0] hwdata, // write data
	input wire hready, // bus ready
	output reg hreadyout, // slave ready
	output reg hresp, // always okay
	output reg [31:0] hrdata, // read data
	output reg irq, // level interrupt
	input wire [5:0] coil_a, // coil drive, slice a
	input wire [5:0] coil_b, // coil drive, slice b
	input wire [5:0] coil_c, // coil drive, slice c
	input wire [5:0] trip_a, // trip state, slice a
	input wire [5:0] trip_b, // trip state, slice b
	input wire [5:0] trip_c, // trip state, slice c
	input wire [2:0] test_a, // test state, slice a
	input wire [2:0] test_b, // test state, slice b
	input wire [2:0] test_c, // test state, slice c
	input wire [`TDH_NUM_HK*RAW_W-1:0] hk_raw // raw readings
);

	localparam NF = `TDH_NUM_FLAGS;
	localparam NH = `TDH_NUM_HK;
	localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

	// ----------------------------------------
	// slice state synchronisers
	// ----------------------------------------

	wire [NF-1:0] raw_a;
	wire [NF-1:0] raw_b;
	wire [NF-1:0] raw_c;
	reg [NF-1:0] meta_a;
	reg [NF-1:0] meta_b;
	reg [NF-1:0] meta_c;
	reg [NF-1:0] st_a;
	reg [NF-1:0] st_b;
	reg [NF-1:0] st_c;

	// flag order: coil 0-5, trip 6-11, test 12-14
	assign raw_a = {test_a, trip_a, coil_a};
	assign raw_b = {test_b, trip_b, coil_b};
	assign raw_c = {test_c, trip_c, coil_c};

	// two flops per bit, first stage read only by second
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_a <= {NF{1'b0}};
			meta_b <= {NF{1'b0}};
			meta_c <= {NF{1'b0}};
			st_a <= {NF{1'b0}};
			st_b <= {NF{1'b0}};
			st_c <= {NF{1'b0}};
		end else begin
			meta_a <= raw_a;
			meta_b <= raw_b;
			meta_c <= raw_c;
			st_a <= meta_a;
			st_b <= meta_b;
			st_c <= meta_c;
		end
	end

	// ----------------------------------------
	// duration tick divider
	// ----------------------------------------

	reg [31:0] tick_cnt;
	reg tick;

	// one-cycle enable every tick period
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt <= 32'h00000000;
			tick <= 1'b0;
		end else if (tick_cnt >= TICK_LAST) begin
			tick_cnt <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// persistence counters and flags
	// ----------------------------------------

	reg [CNT_W-1:0] limit;
	reg [NF-1:0] flag;
	wire [NF-1:0] next_flag;

	genvar gi;
	generate
		for (gi = 0; gi < NF; gi = gi + 1) begin : g_flag
			reg [CNT_W-1:0] cnt;
			wire agree;
			assign agree = (st_a[gi] == st_b[gi]) &&
				(st_b[gi] == st_c[gi]);
			// restart on agreement, count ticks otherwise
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt <= {CNT_W{1'b0}};
				end else if (agree) begin
					cnt <= {CNT_W{1'b0}};
				end else if (tick && cnt != CNT_MAX) begin
					cnt <= cnt + 1'b1;
				end
			end
			// set only beyond the limit, clear on agreement
			assign next_flag[gi] = !agree && (cnt > limit);
		end
	endgenerate

	// registered flag vector
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag <= {NF{1'b0}};
		end else begin
			flag <= next_flag;
		end
	end

	// ----------------------------------------
	// discrepancy word packing
	// ----------------------------------------

	wire [15:0] disc1;
	wire [15:0] disc2;
	wire [15:0] disc3;

	// rpm bits 0-8 not carried here
	assign disc1[8:0] = 9'h000;
	// group 1 coil drive: over-speed, over-acceleration
	assign disc1[`TDH_W1_COIL_LSB] = flag[0];
	assign disc1[`TDH_W1_COIL_LSB+1] = flag[1];
	// group 2 coil drive flags
	assign disc1[11] = flag[2];
	assign disc1[12] = flag[3];
	// group 3 coil drive flags
	assign disc1[13] = flag[4];
	assign disc1[14] = flag[5];
	// group 1 over-speed trip flag
	assign disc1[`TDH_W1_TRIP_BIT] = flag[6];
	// group 1 over-acceleration trip flag
	assign disc2[`TDH_W2_TRIP_LSB] = flag[7];
	// group 2 trip flags
	assign disc2[1] = flag[8];
	assign disc2[2] = flag[9];
	// group 3 trip flags
	assign disc2[3] = flag[10];
	assign disc2[4] = flag[11];
	// over-speed test flags, groups 1 to 3
	assign disc2[`TDH_W2_TEST_LSB] = flag[12];
	assign disc2[6] = flag[13];
	assign disc2[7] = flag[14];
	// reserved bits of the second word
	assign disc2[15:8] = 8'h00;
	// third word wholly reserved
	assign disc3 = 16'h0000;

	// ----------------------------------------
	// health words with saturation
	// ----------------------------------------

	reg [15:0] hk [0:NH-1];

	// index 0-2 input b, 3-5 int volt, 6-8 int curr,
	// 9-11 isolated input, 12-14 input a
	generate
		for (gi = 0; gi < NH; gi = gi + 1) begin : g_hk
			wire [RAW_W-1:0] r;
			wire fits;
			assign r = hk_raw[gi*RAW_W +: RAW_W];
			assign fits = (r[RAW_W-1:15] == {(RAW_W-15){1'b0}}) ||
				(r[RAW_W-1:15] == {(RAW_W-15){1'b1}});
			// two's complement word, clamp out of range
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					hk[gi] <= 16'h0000;
				end else if (fits) begin
					hk[gi] <= r[15:0];
				end else if (r[RAW_W-1]) begin
					hk[gi] <= `TDH_HK_MIN;
				end else begin
					hk[gi] <= `TDH_HK_MAX;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// bus slave
	// ----------------------------------------

	reg wr_pend;
	reg [6:0] wr_addr;
	reg [NF-1:0] imask;
	reg [NF-1:0] istat;
	reg [NF-1:0] flag_d;
	reg [31:0] next_rdata;
	wire accept;
	wire [6:0] a;
	wire [NF-1:0] rise;
	wire do_wr;

	assign accept = hsel && htrans[1] && hready;
	assign a = haddr[6:0];
	assign do_wr = wr_pend;
	assign rise = flag & ~flag_d;

	// read data chosen in the address phase
	always @* begin
		next_rdata = 32'h00000000;
		case (a)
			`TDH_OFS_DISC1: next_rdata = {16'h0000, disc1};
			`TDH_OFS_DISC2: next_rdata = {16'h0000, disc2};
			`TDH_OFS_DISC3: next_rdata = {16'h0000, disc3};
			`TDH_OFS_HK1: next_rdata = {16'h0000, hk[0]};
			`TDH_OFS_HK1 + 7'h04: next_rdata = {16'h0000, hk[1]};
			`TDH_OFS_HK1 + 7'h08: next_rdata = {16'h0000, hk[2]};
			`TDH_OFS_HK1 + 7'h0c: next_rdata = {16'h0000, hk[3]};
			`TDH_OFS_HK1 + 7'h10: next_rdata = {16'h0000, hk[4]};
			`TDH_OFS_HK1 + 7'h14: next_rdata = {16'h0000, hk[5]};
			`TDH_OFS_HK1 + 7'h18: next_rdata = {16'h0000, hk[6]};
			`TDH_OFS_HK1 + 7'h1c: next_rdata = {16'h0000, hk[7]};
			`TDH_OFS_HK1 + 7'h20: next_rdata = {16'h0000, hk[8]};
			`TDH_OFS_HK1 + 7'h24: next_rdata = {16'h0000, hk[9]};
			`TDH_OFS_HK1 + 7'h28: next_rdata = {16'h0000, hk[10]};
			`TDH_OFS_HK1 + 7'h2c: next_rdata = {16'h0000, hk[11]};
			`TDH_OFS_HK1 + 7'h30: next_rdata = {16'h0000, hk[12]};
			`TDH_OFS_HK1 + 7'h34: next_rdata = {16'h0000, hk[13]};
			`TDH_OFS_HK1 + 7'h38: next_rdata = {16'h0000, hk[14]};
			`TDH_OFS_LIMIT: next_rdata = {{(32-CNT_W){1'b0}}, limit};
			`TDH_OFS_ISTAT: next_rdata = {17'h00000, istat};
			`TDH_OFS_IMASK: next_rdata = {17'h00000, imask};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// address capture; writes add one wait state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 7'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
		end else begin
			if (accept) begin
				wr_pend <= hwrite;
				wr_addr <= a;
				hreadyout <= !hwrite;
				hrdata <= hwrite ? 32'h00000000 : next_rdata;
			end else begin
				wr_pend <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end

	// response is always okay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// writable registers, written in the wait state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			limit <= `TDH_LIMIT_RST;
			imask <= `TDH_IMASK_RST;
		end else if (do_wr) begin
			if (wr_addr == `TDH_OFS_LIMIT) begin
				limit <= hwdata[CNT_W-1:0];
			end
			if (wr_addr == `TDH_OFS_IMASK) begin
				imask <= hwdata[NF-1:0];
			end
		end
	end

	// ----------------------------------------
	// interrupt status, mask and output
	// ----------------------------------------

	// previous flag vector for rise detection
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_d <= {NF{1'b0}};
		end else begin
			flag_d <= flag;
		end
	end

	// sticky on flag rise; set wins over write-one clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			istat <= {NF{1'b0}};
		end else begin
			if (do_wr && wr_addr == `TDH_OFS_ISTAT) begin
				istat <= (istat & ~hwdata[NF-1:0]) | rise;
			end else begin
				istat <= istat | rise;
			end
		end
	end

	// level interrupt from unmasked status, registered
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(istat & imask);
		end
	end

endmodule

// ===== tb/tdh_monitor.sv
`timescale 1ns/100ps
module tdh_monitor (
	input wire hclk, // clock
	input wire hresetn, // reset, low
	input wire hsel, // select
	input wire [31:0] haddr, // address
	input wire [1:0] htrans, // transfer
	input wire hwrite, // write
	input wire hready, // bus ready
	input wire hreadyout, // slave ready
	input wire hresp, // response
	input wire [31:0] hrdata, // read data
	input wire irq // interrupt
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
// transfer decode
wire tk = hsel & htrans[1] & hready;
wire rd = tk & !hwrite;
wire [6:0] a = haddr[6:0];
a_resp_okay: assert property (hresp == 1'b0)
	else $error("response not okay");
a_write_wait: assert property (tk && hwrite |=> !hreadyout ##1 hreadyout)
	else $error("write wait state wrong");
a_read_nowait: assert property (rd |=> hreadyout)
	else $error("read stalled");
a_rdata_holds: assert property (!tk |=> $stable(hrdata))
	else $error("read data moved");
a_word1_rpm: assert property (rd && a == 7'h00 |=>
	hrdata[8:0] == 9'h000 && hrdata[31:16] == 16'h0000)
	else $error("word 1 spare bits set");
a_word2_rsvd: assert property (rd && a == 7'h04 |=> hrdata[31:8] == 0)
	else $error("word 2 reserved bits set");
a_word3_zero: assert property (rd && a == 7'h08 |=> hrdata == 0)
	else $error("word 3 not zero");
a_health_width: assert property (rd && a >= 7'h0c && a <= 7'h44 |=>
	hrdata[31:16] == 16'h0000)
	else $error("health word too wide");
c_read: cover property (rd && a == 7'h00);
c_write: cover property (tk && hwrite);
c_irq: cover property ($rose(irq));
endmodule
bind tdh_status tdh_monitor u_mon (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .irq);

// ===== tb/tdh_host.sv
`timescale 1ns/100ps
module tdh_host (
	input wire hclk, // clock
	input wire hresetn, // reset, low
	input wire go, // start transfer
	input wire wr, // write request
	input wire [6:0] a, // offset
	input wire [31:0] wd, // write value
	output reg done, // one cycle pulse
	output reg [31:0] rdv, // read value
	output reg hsel, // select
	output reg [31:0] haddr, // address
	output reg [1:0] htrans, // transfer
	output reg hwrite, // write
	output wire [2:0] hsize, // word size
	output reg [31:0] hwdata, // write data
	input wire hready, // bus ready
	input wire [31:0] hrdata // read data
);
reg [1:0] st;
assign hsize = 3'b010;
// address phase, data phase, release
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		st <= 2'd0;
		done <= 1'b0;
		rdv <= 32'h0;
		hsel <= 1'b0;
		haddr <= 32'h0;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hwdata <= 32'h0;
	end else begin
		done <= 1'b0;
		case (st)
		2'd0: if (go) begin
			hsel <= 1'b1;
			htrans <= 2'b10;
			haddr <= {25'h0, a};
			hwrite <= wr;
			st <= 2'd1;
		end
		2'd1: if (hready) begin
			hsel <= 1'b0;
			htrans <= 2'b00;
			hwdata <= wd;
			st <= 2'd2;
		end
		default: if (hready) begin
			rdv <= hrdata;
			done <= 1'b1;
			hwdata <= ~hwdata; // no stale data after release
			st <= 2'd0;
		end
		endcase
	end
end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
reg hclk, hresetn, go, wr;
reg [6:0] a;
reg [31:0] wd, v;
reg [14:0] s [0:2];
reg [269:0] hk;
wire done, hsel, hwrite, hreadyout, hresp, irq;
wire [31:0] rdv, haddr, hwdata, hrdata;
wire [1:0] htrans;
wire [2:0] hsize;
integer err_total, n_checks, i;
tdh_host u_host (.hclk(hclk), .hresetn(hresetn), .go(go), .wr(wr),
	.a(a), .wd(wd), .done(done), .rdv(rdv), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hreadyout), .hrdata(hrdata));
tdh_status #(.TICK_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
	.coil_a(s[0][5:0]), .coil_b(s[1][5:0]), .coil_c(s[2][5:0]),
	.trip_a(s[0][11:6]), .trip_b(s[1][11:6]), .trip_c(s[2][11:6]),
	.test_a(s[0][14:12]), .test_b(s[1][14:12]), .test_c(s[2][14:12]),
	.hk_raw(hk));
// ----------------------------------------
// bus and check helpers
// ----------------------------------------
task chk(input [31:0] seen, input [31:0] exp);
	begin
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
endtask
task xfer(input w, input [6:0] ad, input [31:0] d);
	integer n;
	begin
		go <= 1'b1;
		wr <= w;
		a <= ad;
		wd <= d;
		@(posedge hclk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge hclk);
			n = n + 1;
		end while (done !== 1'b1 && n < 50);
		v = rdv;
	end
endtask
task tally_and_finish;
	begin
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_reset;
	begin
		xfer(1'b1, 7'h08, 32'hffff);
		for (i = 0; i < 7; i = i + 1) begin
			xfer(1'b0, (i < 3) ? 4 * i : 4 * i + 7'h3c, 32'h0);
			chk(v, (i == 3) ? 32'ha : 32'h0);
		end
	end
endtask
task t_flags;
	begin
		xfer(1'b1, 7'h48, 32'h2);
		for (i = 0; i < 15; i = i + 1) begin
			s[i % 3][i] <= 1'b1;
			repeat (4) @(posedge hclk);
			xfer(1'b0, 7'h00, 32'h0);
			chk(v, 32'h0);
			repeat (40) @(posedge hclk);
			xfer(1'b0, 7'h00, 32'h0);
			chk(v, i < 6 ? 32'h1 << (9 + i) : (i == 6 ? 32'h8000 : 0));
			xfer(1'b0, 7'h04, 32'h0);
			chk(v, i > 6 ? 32'h1 << (i - 7) : 32'h0);
			s[i % 3][i] <= 1'b0;
			repeat (8) @(posedge hclk);
			xfer(1'b0, 7'h00, 32'h0);
			chk(v, 32'h0);
			xfer(1'b0, 7'h04, 32'h0);
			chk(v, 32'h0);
		end
	end
endtask
task t_irq;
	begin
		xfer(1'b0, 7'h4c, 32'h0);
		chk(v, 32'h7fff);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, 7'h50, 32'h1000);
		xfer(1'b0, 7'h50, 32'h0);
		chk(v, 32'h1000);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, 7'h4c, 32'h7fff);
		xfer(1'b0, 7'h4c, 32'h0);
		chk(v, 32'h0);
		chk({31'h0, irq}, 32'h0);
	end
endtask
task t_health;
	begin
		for (i = 3; i < 15; i = i + 1)
			hk[i * 18 +: 18] <= i * 18'h123;
		hk[53:0] <= {18'h3ffff, 18'h20000, 18'h1ffff};
		repeat (3) @(posedge hclk);
		xfer(1'b0, 7'h0c, 32'h0);
		chk(v, 32'h7fff);
		xfer(1'b0, 7'h10, 32'h0);
		chk(v, 32'h8000);
		xfer(1'b0, 7'h14, 32'h0);
		chk(v, 32'hffff);
		for (i = 3; i < 15; i = i + 1) begin
			xfer(1'b0, 7'h0c + 4 * i, 32'h0);
			chk(v, i * 32'h123);
		end
	end
endtask
// ----------------------------------------
// clock, reset, sequence, watchdog
// ----------------------------------------
initial begin
	hclk = 1'b0;
	forever #2.5 hclk = ~hclk;
end
initial begin
	err_total = 0;
	n_checks = 0;
	hresetn = 1'b0;
	go = 1'b0;
	wr = 1'b0;
	a = 7'h0;
	wd = 32'h0;
	hk = 270'h0;
	for (i = 0; i < 3; i = i + 1)
		s[i] = 15'h0;
	repeat (12) @(posedge hclk);
	hresetn <= 1'b1;
	@(posedge hclk);
	t_reset;
	t_flags;
	t_irq;
	t_health;
	tally_and_finish;
end
initial begin
	#60000;
	err_total = err_total + 1;
	tally_and_finish;
end
endmodule
